/* File: rtl/lvds_pixel_serializer.sv */
`timescale 1ns/1ps
module lvds_pixel_serializer #(
    parameter int LOCK_CYCLES = lvds_tx_pkg::LOCK_CYCLES_MAX,
    parameter int MISS_CYCLES = lvds_tx_pkg::MISS_CYCLES_DEF,
    parameter lvds_tx_pkg::bit_map_t BIT_MAP = lvds_tx_pkg::default_map()
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // parallel pixel inputs
    input wire logic [lvds_tx_pkg::COLOR_BITS-1:0] redIn,
    input wire logic [lvds_tx_pkg::COLOR_BITS-1:0] greenIn,
    input wire logic [lvds_tx_pkg::COLOR_BITS-1:0] blueIn,
    input wire logic lineSync,
    input wire logic frameSync,
    input wire logic pixelValid,
    input wire logic spareCtrl,
    input wire logic pixelShiftClockIn,
    // power control
    input wire logic standby_n,
    // serial outputs
    output logic [lvds_tx_pkg::LANES-1:0] serialLanePos,
    output logic [lvds_tx_pkg::LANES-1:0] serialLaneNeg,
    output logic forwardedClockPos,
    output logic forwardedClockNeg,
    output logic outputEnable,
    // status
    output logic pllLocked,
    output logic captureReady
);
    localparam int PB = lvds_tx_pkg::PIX_BITS;
    localparam int NL = lvds_tx_pkg::LANES;
    localparam int SB = lvds_tx_pkg::SYNC_BITS;
    localparam int LW = lvds_tx_pkg::LOCK_W;
    localparam int MW = lvds_tx_pkg::MISS_W;
    localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_CYCLES - 1);
    localparam logic [MW-1:0] MISS_LIMIT = MW'(MISS_CYCLES);

    generate
        if (LOCK_CYCLES < 1 || LOCK_CYCLES > lvds_tx_pkg::LOCK_CYCLES_MAX)
        begin : g_lock_chk
            $error("LOCK_CYCLES out of range");
        end
        if (MISS_CYCLES < 2 || MISS_CYCLES > (1 << MW) - 1) begin : g_miss_chk
            $error("MISS_CYCLES out of range");
        end
        for (genvar k = 0; k < NL * lvds_tx_pkg::SLOTS; k++) begin : g_map_chk
            if (BIT_MAP[k*lvds_tx_pkg::MAP_W +: lvds_tx_pkg::MAP_W] >= PB)
            begin : g_bad
                $error("BIT_MAP entry beyond input word");
            end
        end
    endgenerate

    // every pin passes three flops; a level counts once stages 2 and 3 agree
    wire [PB-1:0] pixelWord = {spareCtrl, pixelValid, frameSync, lineSync,
                               blueIn, greenIn, redIn};
    wire [SB-1:0] pinRaw = {standby_n, pixelShiftClockIn, pixelWord};
    logic [SB-1:0] sync1;
    logic [SB-1:0] sync2;
    logic [SB-1:0] sync3;
    logic [SB-1:0] pinLevel;
    wire [SB-1:0] next_pinLevel = (sync2 & sync3) |
                                  (pinLevel & (sync2 ^ sync3));

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pinLevel <= '0;
        end else begin
            sync1 <= pinRaw;
            sync2 <= sync1;
            sync3 <= sync2;
            pinLevel <= next_pinLevel;
        end
    end

    // the unregistered next level kills outputs one cycle sooner
    wire standbyNow = !next_pinLevel[lvds_tx_pkg::SYNC_STBY];
    wire haltReset = !rst_n || standbyNow;
    wire pixelFall = pinLevel[lvds_tx_pkg::SYNC_CLK] &&
                     !next_pinLevel[lvds_tx_pkg::SYNC_CLK];
    wire [PB-1:0] capturedWord = next_pinLevel[PB-1:0];

    // clock watchdog: a stopped clock drops lock without standby
    logic [MW-1:0] missCount;
    wire clkAlive = (missCount < MISS_LIMIT);
    always_ff @(posedge mclk) begin
        if (haltReset || pixelFall) begin
            missCount <= '0;
        end else if (clkAlive) begin
            missCount <= missCount + 1'b1;
        end
    end

    // lock model: lock counts only while the input clock keeps arriving
    lvds_tx_pkg::link_state_t state;
    lvds_tx_pkg::link_state_t next_state;
    logic [LW-1:0] lockCount;
    wire lockDone = (lockCount == LOCK_LAST);

    always_comb begin
        next_state = state;
        case (state)
            lvds_tx_pkg::ST_STANDBY: next_state = lvds_tx_pkg::ST_LOCKING;
            lvds_tx_pkg::ST_LOCKING: begin
                if (clkAlive && lockDone) begin
                    next_state = lvds_tx_pkg::ST_RUNNING;
                end
            end
            lvds_tx_pkg::ST_RUNNING: begin
                if (!clkAlive) begin
                    next_state = lvds_tx_pkg::ST_LOCKING;
                end
            end
            default: next_state = lvds_tx_pkg::ST_STANDBY;
        endcase
    end

    // no ordering between pins and standby release is needed
    always_ff @(posedge mclk) begin
        if (haltReset) begin
            state <= lvds_tx_pkg::ST_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk) begin
        if (haltReset || state != lvds_tx_pkg::ST_LOCKING || !clkAlive) begin
            lockCount <= '0;
        end else if (!lockDone) begin
            lockCount <= lockCount + 1'b1;
        end
    end

    wire running = (state == lvds_tx_pkg::ST_RUNNING);
    assign pllLocked = running;

    // buffer absorbs the modulated input rate against the fixed slot rate
    wire fifoRst_n = !haltReset && running;
    wire fifoInReady;
    wire fifoOutValid;
    wire [PB-1:0] fifoOutData;
    logic sending;
    logic [2:0] slot;
    wire wordBoundary = !sending || (slot == lvds_tx_pkg::LAST_SLOT);
    wire popWord = wordBoundary && running;
    assign captureReady = fifoInReady && running;

    pixel_fifo #(
        .WIDTH(PB),
        .DEPTH(lvds_tx_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(fifoRst_n),
        .inValid(pixelFall && running),
        .inReady(fifoInReady),
        .inData(capturedWord),
        .outValid(fifoOutValid),
        .outReady(popWord),
        .outData(fifoOutData)
    );

    // slot sequencer; an empty buffer at a boundary inserts an idle gap
    logic [PB-1:0] word;
    always_ff @(posedge mclk) begin
        if (haltReset || !running) begin
            sending <= 1'b0;
            slot <= lvds_tx_pkg::FIRST_SLOT;
            word <= '0;
        end else if (wordBoundary) begin
            sending <= fifoOutValid;
            slot <= lvds_tx_pkg::FIRST_SLOT;
            if (fifoOutValid) word <= fifoOutData;
        end else begin
            slot <= slot + 1'b1;
        end
    end

    wire [NL-1:0] laneBit;
    generate
        for (genvar l = 0; l < NL; l++) begin : g_lane
            assign laneBit[l] =
                word[lvds_tx_pkg::map_index(BIT_MAP, l, slot)];
        end
    endgenerate
    wire fwdBit = lvds_tx_pkg::FWD_CLK_PATTERN[slot];

    // idle slots hold the forwarded clock level to avoid a runt pulse
    always_ff @(posedge mclk) begin
        if (haltReset || !running) begin
            serialLanePos <= '0;
            serialLaneNeg <= '1;
            forwardedClockPos <= 1'b0;
            forwardedClockNeg <= 1'b1;
        end else if (sending) begin
            serialLanePos <= laneBit;
            serialLaneNeg <= ~laneBit;
            forwardedClockPos <= fwdBit;
            forwardedClockNeg <= ~fwdBit;
        end
    end

    always_ff @(posedge mclk) begin
        if (haltReset) begin
            outputEnable <= 1'b0;
        end else begin
            outputEnable <= 1'b1;
        end
    end

    // checks
    localparam int LOCK_BOUND = 1000;

    AST_CAPTURE_FALL: assert property (
        @(posedge mclk) disable iff (!rst_n)
        running && !standbyNow && $fell(pinLevel[lvds_tx_pkg::SYNC_CLK])
        |-> $past(pixelFall))
        else $error("falling pixel clock not seen as capture");

    // with settled stages the control and red fields must be the pins three edges back
    AST_WORD_LAYOUT: assert property (
        @(posedge mclk) disable iff (!rst_n)
        pixelFall && sync2[PB-1:0] == sync3[PB-1:0] |->
            capturedWord[lvds_tx_pkg::CTRL_LSB +: lvds_tx_pkg::CTRL_BITS] ==
            $past({spareCtrl, pixelValid, frameSync, lineSync}, 3) &&
            capturedWord[lvds_tx_pkg::RED_LSB +: lvds_tx_pkg::COLOR_BITS] ==
            $past(redIn, 3))
        else $error("pixel word fields misplaced");

    AST_DIFF_PAIR: assert property (
        @(posedge mclk) disable iff (!rst_n)
        serialLaneNeg == ~serialLanePos &&
        forwardedClockNeg == !forwardedClockPos)
        else $error("differential legs not complementary");

    AST_FWD_CLK: assert property (
        @(posedge mclk) disable iff (haltReset)
        running && sending |=> forwardedClockPos ==
            $past(lvds_tx_pkg::FWD_CLK_PATTERN[slot]))
        else $error("forwarded clock off its slot pattern");

    AST_STANDBY_OFF: assert property (
        @(posedge mclk) disable iff (!rst_n)
        standbyNow |=> !outputEnable && !pllLocked)
        else $error("outputs active during standby");

    AST_STANDBY_RESET: assert property (
        @(posedge mclk) disable iff (!rst_n)
        standbyNow |=> state == lvds_tx_pkg::ST_STANDBY && !sending
            && lockCount == '0)
        else $error("standby did not reset internal state");

    AST_PD_DELAY: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $fell(standby_n) ##1 !standby_n [*4]
        |-> !outputEnable)
        else $error("outputs not disabled within 100 ns");

    AST_LOCK: assert property (
        @(posedge mclk) disable iff (haltReset)
        state == lvds_tx_pkg::ST_LOCKING && clkAlive && lockDone
        |=> pllLocked)
        else $error("lock not reached at lock count");

    AST_LOCK_BOUND: assert property (
        @(posedge mclk) disable iff (haltReset)
        int'(lockCount) <= LOCK_CYCLES - 1)
        else $error("lock count beyond lock time");

    AST_CLOCK_LOSS: assert property (
        @(posedge mclk) disable iff (haltReset)
        running && !clkAlive |=> !pllLocked ##1
            state == lvds_tx_pkg::ST_LOCKING)
        else $error("stopped clock did not drop lock");

    // a lock loss mid word clears the sequencer, so only running words count
    AST_SLOT_RANGE: assert property (
        @(posedge mclk) disable iff (haltReset)
        running && sending && slot != lvds_tx_pkg::LAST_SLOT |=>
            sending && slot == $past(slot) + 3'h1)
        else $error("slot sequence broken");

    AST_TRACK: assert property (
        @(posedge mclk) disable iff (haltReset)
        running && wordBoundary && fifoOutValid |=> sending &&
            slot == lvds_tx_pkg::FIRST_SLOT)
        else $error("buffered word not started at boundary");

    AST_MAP_LANE0: assert property (
        @(posedge mclk) disable iff (haltReset)
        running && sending |=> serialLanePos[0] ==
            $past(word[lvds_tx_pkg::map_index(BIT_MAP, 0, slot)]))
        else $error("lane 0 bit not from mapped input bit");

    COV_LOCKED: cover property (@(posedge mclk) disable iff (haltReset)
        state == lvds_tx_pkg::ST_LOCKING ##1 running);
    COV_WORD_SENT: cover property (@(posedge mclk) disable iff (haltReset)
        sending && slot == lvds_tx_pkg::LAST_SLOT);
    COV_RELOCK: cover property (@(posedge mclk) disable iff (haltReset)
        running ##1 !running ##[1:LOCK_BOUND] running);
    COV_STANDBY_RUN: cover property (@(posedge mclk) disable iff (!rst_n)
        running ##1 standbyNow);
endmodule : lvds_pixel_serializer

/* File: rtl/lvds_tx_pkg.sv */
// Functional notes
// - accept 24 colour bits plus four control lines as one 28-bit word
// - capture the word on the falling pixel clock edge only
// - four differential data lanes, each with positive and negative leg
// - forward a clock derived from the pixel clock on a fifth pair
// - while standby_n is low, all serial outputs are disabled
// - standby resets internal state and stops the lock logic
// - clock and data may start before or after standby release
// - recover from a stopped and restarted clock without standby
// - output rate follows a modulated input clock through the buffer
// - each lane sends seven slots, 0 to 6, per forwarded clock period
// - lock and valid output within 10 ms of a stable clock
// - outputs disabled within 100 ns of standby assertion
package lvds_tx_pkg;
    localparam int PIX_BITS = 28;
    localparam int COLOR_BITS = 8;
    localparam int CTRL_BITS = 4;
    localparam int LANES = 4;
    localparam int SLOTS = 7;
    localparam int MAP_W = 5;
    localparam int FIFO_DEPTH = 16;
    // word layout
    localparam int RED_LSB = 0;
    localparam int GREEN_LSB = 8;
    localparam int BLUE_LSB = 16;
    localparam int CTRL_LSB = 24;
    // synchroniser vector layout: data, pixel clock, standby
    localparam int SYNC_BITS = PIX_BITS + 2;
    localparam int SYNC_CLK = PIX_BITS;
    localparam int SYNC_STBY = PIX_BITS + 1;
    // timing
    localparam int MCLK_HZ = 50_000_000;
    localparam int MCLK_PERIOD_NS = 20;
    localparam int LOCK_TIME_MS = 10;
    localparam int LOCK_CYCLES_MAX = LOCK_TIME_MS * (MCLK_HZ / 1000);
    localparam int LOCK_W = $clog2(LOCK_CYCLES_MAX + 1);
    localparam int PD_DELAY_NS = 100;
    localparam int PD_CYCLES = PD_DELAY_NS / MCLK_PERIOD_NS;
    localparam int MISS_CYCLES_DEF = 64;
    localparam int MISS_W = 8;
    // slot sequencing; forwarded clock level per slot, slot 0 in bit 0
    localparam logic [2:0] FIRST_SLOT = 3'h0;
    localparam logic [2:0] LAST_SLOT = 3'h6;
    localparam logic [6:0] FWD_CLK_PATTERN = 7'h47;

    typedef logic [LANES*SLOTS*MAP_W-1:0] bit_map_t;

    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_LOCKING = 2'b01,
        ST_RUNNING = 2'b10
    } link_state_t;

    // default: seven consecutive input bits per lane, in input order
    function automatic bit_map_t default_map();
        bit_map_t m;
        m = '0;
        for (int i = 0; i < LANES * SLOTS; i++) begin
            m[i*MAP_W +: MAP_W] = MAP_W'(i);
        end
        return m;
    endfunction : default_map

    function automatic logic [MAP_W-1:0] map_index(
        input bit_map_t m, input int lane, input logic [2:0] slot);
        int pos;
        pos = lane * SLOTS + int'(slot);
        return m[pos*MAP_W +: MAP_W];
    endfunction : map_index
endpackage : lvds_tx_pkg

/* File: rtl/pixel_fifo.sv */
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
            $error("pixel_fifo: DEPTH must be a power of two, WIDTH >= 1");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    wire full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
    wire empty = (wrPtr == rdPtr);
    wire doWrite = inValid && !full;
    wire doRead = outReady && !empty;

    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (doWrite) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (doWrite) wrPtr <= wrPtr + 1'b1;
            if (doRead) rdPtr <= rdPtr + 1'b1;
        end
    end
endmodule : pixel_fifo

/* File: verification/display_receiver_model.sv */
`timescale 1ns/1ps
module display_receiver_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // serial side
    input wire logic [3:0] lanePos,
    input wire logic fwdClkPos,
    input wire logic enable,
    // recovered words
    output logic rxValid,
    output logic [27:0] rxWord
);
    logic [11:0] hist;
    logic [3:0] slots [0:6];
    logic prevClk;
    int cnt;
    // the only clock fall sits at slot 3, so slots 0..2 are the last 3 cycles
    always_ff @(posedge mclk) begin
        rxValid <= 1'b0;
        prevClk <= fwdClkPos;
        hist <= {hist[7:0], lanePos};
        if (!rst_n || !enable) begin
            cnt <= 0;
            prevClk <= 1'b0;
        end else if (prevClk && !fwdClkPos) begin
            slots[0] <= hist[11:8];
            slots[1] <= hist[7:4];
            slots[2] <= hist[3:0];
            slots[3] <= lanePos;
            cnt <= 4;
        end else if (cnt != 0) begin
            slots[cnt] <= lanePos;
            rxValid <= (cnt == 6);
            cnt <= (cnt == 6) ? 0 : cnt + 1;
        end
    end
    // default table: lane l slot s carries input bit l*7+s
    always_comb begin
        for (int l = 0; l < 4; l++) begin
            for (int s = 0; s < 7; s++) begin
                rxWord[l*7+s] = slots[s][l];
            end
        end
    end
endmodule : display_receiver_model

/* File: verification/tb_lvds_pixel_serializer.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
error_cnt++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_lvds_pixel_serializer;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic standby_n = 1'b1;
    logic pclk = 1'b1;
    logic [27:0] pinWord = '0;
    logic [3:0] serialLanePos, serialLaneNeg;
    logic forwardedClockPos, forwardedClockNeg;
    logic outputEnable, pllLocked, captureReady, rxValid;
    logic [27:0] rxWord, expWord;
    logic [27:0] expq [$];
    int error_cnt = 0;
    int compares = 0;
    bit armed = 0;
    bit sawFull = 0;

    initial forever #10 mclk = ~mclk;

    lvds_pixel_serializer #(.LOCK_CYCLES(20), .MISS_CYCLES(40)) i_dut (
        .mclk(mclk), .rst_n(rst_n),
        .redIn(pinWord[7:0]), .greenIn(pinWord[15:8]),
        .blueIn(pinWord[23:16]), .lineSync(pinWord[24]),
        .frameSync(pinWord[25]), .pixelValid(pinWord[26]),
        .spareCtrl(pinWord[27]), .pixelShiftClockIn(pclk),
        .standby_n(standby_n),
        .serialLanePos(serialLanePos), .serialLaneNeg(serialLaneNeg),
        .forwardedClockPos(forwardedClockPos),
        .forwardedClockNeg(forwardedClockNeg),
        .outputEnable(outputEnable), .pllLocked(pllLocked),
        .captureReady(captureReady));

    display_receiver_model i_rx (
        .mclk(mclk), .rst_n(rst_n), .lanePos(serialLanePos),
        .fwdClkPos(forwardedClockPos), .enable(outputEnable),
        .rxValid(rxValid), .rxWord(rxWord));

    always @(posedge mclk) begin
        if (armed && rxValid === 1'b1) begin
            if (expq.size() == 0) begin
                `CHK("extra word", 1'b0, 1'b1)
            end else begin
                expWord = expq.pop_front();
                `CHK("word", expWord, rxWord)
            end
        end
        if (rst_n && outputEnable === 1'b1) begin
            `CHK("lane neg", ~serialLanePos, serialLaneNeg)
            `CHK("clock neg", ~forwardedClockPos, forwardedClockNeg)
        end
        if (captureReady === 1'b0 && pllLocked === 1'b1) sawFull = 1'b1;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // junk at the rising edge, so a rising-edge sampler sends the wrong word
    task automatic send_word(input logic [27:0] w, input int hi, input int lo);
        @(negedge mclk);
        pclk = 1'b1;
        pinWord = 28'($urandom);
        @(negedge mclk);
        pinWord = w;
        repeat (hi - 1) @(negedge mclk);
        pclk = 1'b0;
        if (armed) expq.push_back(w);
        repeat (lo - 1) @(negedge mclk);
    endtask : send_word

    // period 7..11 cycles: a wandering rate like a modulated clock
    task automatic stream(input int n);
        repeat (n) begin
            send_word(28'($urandom), 4 + $urandom % 3,
                      3 + $urandom % 3);
        end
    endtask : stream

    task automatic relock();
        armed = 0;
        repeat (5) send_word(28'($urandom), 5, 5);
        `CHK("locked", 1'b1, pllLocked)
        `CHK("enable", 1'b1, outputEnable)
        repeat (25) @(negedge mclk);
        armed = 1;
    endtask : relock

    task automatic drain();
        repeat (25) @(negedge mclk);
        `CHK("pending", 0, expq.size())
        armed = 0;
    endtask : drain

    initial begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'hb4b6));
        repeat (2) @(negedge mclk);
        `CHK("reset enable", 1'b0, outputEnable)
        `CHK("reset locked", 1'b0, pllLocked)
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        // pixel clock only starts well after release
        repeat (30) @(negedge mclk);
        relock();
        stream(30);
        drain();
        // flood faster than the slot rate, then stop the pixel clock
        repeat (150) send_word(28'($urandom), 3, 3);
        `CHK("buffer refused", 1'b1, sawFull)
        repeat (150) @(negedge mclk);
        `CHK("lost lock", 1'b0, pllLocked)
        `CHK("idle lanes", 4'h0, serialLanePos)
        `CHK("idle enable", 1'b1, outputEnable)
        // restart without cycling standby
        relock();
        stream(30);
        drain();
        standby_n = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        `CHK("standby enable", 1'b0, outputEnable)
        `CHK("standby locked", 1'b0, pllLocked)
        repeat (4) send_word(28'($urandom), 5, 5);
        `CHK("standby hold", 1'b0, pllLocked)
        `CHK("standby tristate", 1'b0, outputEnable)
        // source pulses standby, then brings a clean clock
        standby_n = 1'b1;
        repeat (20) @(negedge mclk);
        relock();
        stream(30);
        drain();
        end_of_test();
    end
endmodule : tb_lvds_pixel_serializer
